//--- lmx_pkg.sv
// shared constants for the literal and indirect move execution block
package lmx_pkg;
	// opcode patterns of the 14-bit instruction word
	localparam logic [13:0] LMX_OP_BANK_MASK  = 14'h3fe0;
	localparam logic [13:0] LMX_OP_BANK_VAL   = 14'h0020;
	localparam logic [13:0] LMX_OP_PLAT_MASK  = 14'h3f80;
	localparam logic [13:0] LMX_OP_PLAT_VAL   = 14'h3180;
	localparam logic [13:0] LMX_OP_ACCL_MASK  = 14'h3f00;
	localparam logic [13:0] LMX_OP_ACCL_VAL   = 14'h3000;
	localparam logic [13:0] LMX_OP_FILE_MASK  = 14'h3f80;
	localparam logic [13:0] LMX_OP_FILE_VAL   = 14'h0080;
	localparam logic [13:0] LMX_OP_INDM_MASK  = 14'h3ff8;
	localparam logic [13:0] LMX_OP_INDM_VAL   = 14'h0018;
	localparam logic [13:0] LMX_OP_INDK_MASK  = 14'h3f80;
	localparam logic [13:0] LMX_OP_INDK_VAL   = 14'h3f80;
	// field positions
	localparam int LMX_PTR_SEL_BIT_M = 2;
	localparam int LMX_PTR_SEL_BIT_K = 6;
	localparam int LMX_MODE_LSB      = 0;
	// pointer_update_code encodings
	localparam logic [1:0] LMX_MODE_PREINC  = 2'h0;
	localparam logic [1:0] LMX_MODE_PREDEC  = 2'h1;
	localparam logic [1:0] LMX_MODE_POSTINC = 2'h2;
	localparam logic [1:0] LMX_MODE_POSTDEC = 2'h3;
	// data address of the indirect_data_alias for each pointer
	localparam logic [6:0] LMX_ALIAS0_ADDR = 7'h00;
	localparam logic [6:0] LMX_ALIAS1_ADDR = 7'h01;
	// reset values and the pointer step
	localparam logic [4:0]  LMX_BANK_RST = 5'h00;
	localparam logic [6:0]  LMX_PLAT_RST = 7'h00;
	localparam logic [7:0]  LMX_ACC_RST  = 8'h00;
	localparam logic [15:0] LMX_PTR_RST  = 16'h0000;
	localparam logic [15:0] LMX_ONE      = 16'h0001;
endpackage : lmx_pkg

//--- lmx_move_exec.sv
// execution of literal, file and indirect store move instructions
`timescale 1ns/1ps

// What this block does
// - bank-select literal load copies 5-bit operand into bank select, flags untouched.
// - program-latch literal load copies 7-bit operand into high latch, flags untouched.
// - accumulator literal load places 8-bit operand into working register, no flags.
// - unused bits of accumulator literal opcode are assembled as zero.
// - accumulator-to-file writes working register to 7-bit file address, flags untouched.
// - indirect store writes accumulator at pointer+1, pointer-1, pointer (post modes) or pointer+signed offset.
// - mode code 00/01/10/11 selects pre-inc, pre-dec, post-inc, post-dec.
// - pointer ends plus one, minus one, or unchanged for relative form.
// - file stores to the alias address are redirected to the pointer's address; indirect stores are not.
// - the 16-bit pointer wraps modulo its full range.
// - pointer update and indirect store alter no status flag.
module lmx_move_exec
	import lmx_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	// decoded instruction from fetch
	input  wire logic        instr_valid_i,
	input  wire logic [13:0] instr_i,
	// data memory write port
	output logic             mem_we_o,
	output logic [15:0]      mem_addr_o,
	output logic [7:0]       mem_wdata_o,
	// architectural state, flag write enable and stall
	output logic [7:0]       accumulator_o,
	output logic [4:0]       bank_select_reg_o,
	output logic [6:0]       program_counter_high_latch_o,
	output logic [15:0]      indirect_pointer0_o,
	output logic [15:0]      indirect_pointer1_o,
	output logic             flags_we_o,
	output logic             stall_o
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic op_match(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
		op_match = (w & m) == v;
	endfunction : op_match

	logic [7:0]  accumulator;
	logic [4:0]  bank_select_reg;
	logic [6:0]  program_counter_high_latch;
	logic [15:0] indirect_pointer [2];
	logic        is_bank;
	logic        is_plat;
	logic        is_accl;
	logic        is_file;
	logic        is_indm;
	logic        is_indk;
	logic        ptr_sel;
	logic [1:0]  mode;
	logic [15:0] sel_ptr;
	logic [15:0] ofs;
	logic [15:0] next_ptr;
	logic [15:0] eff_addr;
	logic [15:0] file_addr;

	assign is_bank = instr_valid_i && op_match(instr_i, LMX_OP_BANK_MASK, LMX_OP_BANK_VAL);
	assign is_plat = instr_valid_i && op_match(instr_i, LMX_OP_PLAT_MASK, LMX_OP_PLAT_VAL);
	// only the low byte of this opcode is the literal; the don't-care bits are zero
	assign is_accl = instr_valid_i && op_match(instr_i, LMX_OP_ACCL_MASK, LMX_OP_ACCL_VAL);
	assign is_file = instr_valid_i && op_match(instr_i, LMX_OP_FILE_MASK, LMX_OP_FILE_VAL);
	assign is_indm = instr_valid_i && op_match(instr_i, LMX_OP_INDM_MASK, LMX_OP_INDM_VAL);
	assign is_indk = instr_valid_i && op_match(instr_i, LMX_OP_INDK_MASK, LMX_OP_INDK_VAL);

	////////////////////////////////////////////////////////////////////////////
	// indirect address generation
	always_comb
	begin
		ptr_sel  = is_indk ? instr_i[LMX_PTR_SEL_BIT_K] : instr_i[LMX_PTR_SEL_BIT_M];
		mode     = instr_i[LMX_MODE_LSB +: 2];
		sel_ptr  = indirect_pointer[ptr_sel];
		ofs      = {{10{instr_i[5]}}, instr_i[5:0]};
		next_ptr = sel_ptr;
		eff_addr = sel_ptr;
		if (is_indk)
			eff_addr = sel_ptr + ofs;
		else
		begin
			// 16-bit arithmetic wraps naturally
			case (mode)
				LMX_MODE_PREINC:  next_ptr = sel_ptr + LMX_ONE;
				LMX_MODE_PREDEC:  next_ptr = sel_ptr - LMX_ONE;
				LMX_MODE_POSTINC: next_ptr = sel_ptr + LMX_ONE;
				default:          next_ptr = sel_ptr - LMX_ONE;
			endcase
			eff_addr = (mode[1] == 1'b0) ? next_ptr : sel_ptr;
		end
	end

	// alias addresses in a file store never reach a physical register; indirect stores are not redirected
	always_comb
	begin
		file_addr = {9'h000, instr_i[6:0]};
		if (instr_i[6:0] == LMX_ALIAS0_ADDR)
			file_addr = indirect_pointer[0];
		else if (instr_i[6:0] == LMX_ALIAS1_ADDR)
			file_addr = indirect_pointer[1];
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
			bank_select_reg <= LMX_BANK_RST;
		else if (is_bank)
			bank_select_reg <= instr_i[4:0];

	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
			program_counter_high_latch <= LMX_PLAT_RST;
		else if (is_plat)
			program_counter_high_latch <= instr_i[6:0];

	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
			accumulator <= LMX_ACC_RST;
		else if (is_accl)
			accumulator <= instr_i[7:0];

	// relative form leaves the pointer alone
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			indirect_pointer[0] <= LMX_PTR_RST;
			indirect_pointer[1] <= LMX_PTR_RST;
		end
		else if (is_indm)
			indirect_pointer[ptr_sel] <= next_ptr;

	// one registered write per store instruction, the cycle after issue
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			mem_we_o    <= 1'b0;
			mem_addr_o  <= 16'h0000;
			mem_wdata_o <= 8'h00;
		end
		else
		begin
			mem_we_o <= is_file || is_indm || is_indk;
			if (is_file)
			begin
				mem_addr_o  <= file_addr;
				mem_wdata_o <= accumulator;
			end
			else if (is_indm || is_indk)
			begin
				mem_addr_o  <= eff_addr;
				mem_wdata_o <= accumulator;
			end
		end

	// no move touches a status flag and none stalls
	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			flags_we_o <= 1'b0;
			stall_o    <= 1'b0;
		end
		else
		begin
			flags_we_o <= 1'b0;
			stall_o    <= 1'b0;
		end

	always_ff @(posedge mclk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			accumulator_o                <= LMX_ACC_RST;
			bank_select_reg_o            <= LMX_BANK_RST;
			program_counter_high_latch_o <= LMX_PLAT_RST;
			indirect_pointer0_o          <= LMX_PTR_RST;
			indirect_pointer1_o          <= LMX_PTR_RST;
		end
		else
		begin
			accumulator_o                <= accumulator;
			bank_select_reg_o            <= bank_select_reg;
			program_counter_high_latch_o <= program_counter_high_latch;
			indirect_pointer0_o          <= indirect_pointer[0];
			indirect_pointer1_o          <= indirect_pointer[1];
		end

	////////////////////////////////////////////////////////////////////////////
	bank_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		is_bank |=> ##1 (bank_select_reg_o == $past(instr_i[4:0], 2)))
		else $error("bank select not loaded");

	plat_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		is_plat |=> (program_counter_high_latch == $past(instr_i[6:0])))
		else $error("high latch not loaded");

	acc_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		is_accl |=> (accumulator == $past(instr_i[7:0])))
		else $error("accumulator not loaded");

	file_store_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_file && instr_i[6:1] != 6'h00) |=> (mem_we_o && mem_addr_o == {9'h000, $past(instr_i[6:0])}
		&& mem_wdata_o == $past(accumulator)))
		else $error("file store wrong");

	rel_store_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		is_indk |=> (mem_we_o && mem_addr_o == $past(sel_ptr) + $past(ofs)))
		else $error("relative address wrong");

	pre_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && !mode[1]) |=> (mem_addr_o == $past(next_ptr)))
		else $error("preupdate address wrong");

	ptr_update_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && !mode[0] && !ptr_sel) |=> (indirect_pointer[0] == 16'($past(indirect_pointer[0]) + 16'h0001)))
		else $error("pointer increment wrong");

	ptr_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && mode[0] && !ptr_sel && indirect_pointer[0] == 16'h0000) |=>
		(indirect_pointer[0] == 16'hffff))
		else $error("pointer wrap wrong");

	alias_redirect_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_file && instr_i[6:0] == LMX_ALIAS1_ADDR) |=> (mem_addr_o == $past(indirect_pointer[1])))
		else $error("alias not redirected");

	no_flags_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		instr_valid_i |-> ##1 !flags_we_o ##1 !flags_we_o)
		else $error("status flags touched");

	no_stall_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_file || is_indm || is_indk) |=> (mem_we_o && !stall_o))
		else $error("store not in one cycle");

	////////////////////////////////////////////////////////////////////////////
	// registers must hold when their own load is absent, or a stray decode would go unseen
	bank_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!is_bank |=> (bank_select_reg == $past(bank_select_reg)))
		else $error("bank select changed");

	plat_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!is_plat |=> (program_counter_high_latch == $past(program_counter_high_latch)))
		else $error("high latch changed");

	acc_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!is_accl |=> (accumulator == $past(accumulator)))
		else $error("accumulator changed");

	acc_dontcare_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(instr_valid_i && instr_i[13:10] == LMX_OP_ACCL_VAL[13:10] && instr_i[9:8] != 2'h0) |=>
		(accumulator == $past(accumulator)))
		else $error("dont care bits taken as literal");

	alias0_redirect_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_file && instr_i[6:0] == LMX_ALIAS0_ADDR) |=> (mem_addr_o == $past(indirect_pointer[0])))
		else $error("alias 0 not redirected");

	rel_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		is_indk |=> (indirect_pointer[0] == $past(indirect_pointer[0])
		&& indirect_pointer[1] == $past(indirect_pointer[1])))
		else $error("relative form moved pointer");

	post_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && mode[1]) |=> (mem_addr_o == $past(sel_ptr)))
		else $error("postupdate address wrong");

	preinc_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && mode == LMX_MODE_PREINC) |=>
		(mem_addr_o == 16'($past(sel_ptr) + 16'h0001)))
		else $error("preincrement address wrong");

	predec_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && mode == LMX_MODE_PREDEC) |=>
		(mem_addr_o == 16'($past(sel_ptr) - 16'h0001)))
		else $error("predecrement address wrong");

	ptr_decr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && mode[0] && ptr_sel) |=>
		(indirect_pointer[1] == 16'($past(indirect_pointer[1]) - 16'h0001)))
		else $error("pointer decrement wrong");

	ptr_top_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && !mode[0] && ptr_sel && indirect_pointer[1] == 16'hffff) |=>
		(indirect_pointer[1] == 16'h0000))
		else $error("pointer top wrap wrong");

	ind_data_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm || is_indk) |=> (mem_wdata_o == $past(accumulator)))
		else $error("indirect data wrong");

	store_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!(is_file || is_indm || is_indk) |=> !mem_we_o)
		else $error("write without store");

	ind_flags_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm || is_indk) |=> !flags_we_o)
		else $error("indirect store touched flags");

	// the mirrors trade one cycle of lag for flip-flop driven outputs
	mirror_lag_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		1'b1 |=> (accumulator_o == $past(accumulator) && bank_select_reg_o == $past(bank_select_reg)
		&& indirect_pointer0_o == $past(indirect_pointer[0]) && indirect_pointer1_o == $past(indirect_pointer[1])))
		else $error("state mirror wrong");

	other_ptr_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(is_indm && !ptr_sel) |=> (indirect_pointer[1] == $past(indirect_pointer[1])))
		else $error("unselected pointer moved");

endmodule : lmx_move_exec

//--- lmx_mem_model.sv
// data memory model that records every write from the move block
`timescale 1ns/1ps

module lmx_mem_model
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	// write port from the block
	input  wire logic        mem_we_i,
	input  wire logic [15:0] mem_addr_i,
	input  wire logic [7:0]  mem_wdata_i,
	// record of what was written
	output logic [15:0]      last_addr_o,
	output logic [7:0]       last_data_o,
	output logic [15:0]      writes_o
);
	// a strobe held high too long shows up as extra writes
	always_ff @(posedge mclk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			writes_o    <= 16'h0000;
			last_addr_o <= 16'h0000;
			last_data_o <= 8'h00;
		end
		else if (mem_we_i)
		begin
			writes_o    <= writes_o + 16'h0001;
			last_addr_o <= mem_addr_i;
			last_data_o <= mem_wdata_i;
		end
	end
endmodule : lmx_mem_model

//--- lmx_move_exec_bench.sv
// self-checking bench for the move execution block
`timescale 1ns/1ps

module lmx_move_exec_bench;
	import lmx_pkg::*;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, instr_valid_i = 1'b0, mem_we_o, flags_we_o, stall_o;
	logic [13:0] instr_i = 14'h0000;
	logic [15:0] mem_addr_o, indirect_pointer0_o, indirect_pointer1_o, last_addr, writes, wr_e;
	logic [7:0]  mem_wdata_o, accumulator_o, last_data, acc_e;
	logic [4:0]  bank_select_reg_o;
	logic [6:0]  program_counter_high_latch_o;
	logic [15:0] ptr_e [2];
	int error_cnt = 0, comparisons = 0;
	always #12.5 mclk_i = ~mclk_i;
	lmx_move_exec dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .accumulator_o(accumulator_o),
		.bank_select_reg_o(bank_select_reg_o), .program_counter_high_latch_o(program_counter_high_latch_o),
		.indirect_pointer0_o(indirect_pointer0_o), .indirect_pointer1_o(indirect_pointer1_o),
		.flags_we_o(flags_we_o), .stall_o(stall_o));
	lmx_mem_model mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .last_addr_o(last_addr), .last_data_o(last_data), .writes_o(writes));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic put(input logic [13:0] w);
		instr_i       <= w;
		instr_valid_i <= 1'b1;
		@(posedge mclk_i);
	endtask : put
	// settle time covers the mirror lag of the state outputs
	task automatic idle();
		instr_valid_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask : idle
	task automatic chk_store(input logic [15:0] eff);
		wr_e++;
		chk("writes", writes, wr_e);
		chk("addr", last_addr, eff);
		chk("data", {8'h00, last_data}, {8'h00, acc_e});
		chk("flags", {15'h0, flags_we_o}, 16'h0);
	endtask : chk_store
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_literals();
		put(14'h003f);
		put(14'h31ff);
		put(14'h30a5); // upper literal bits assembled as zero
		put(14'h325a); // a set don't-care bit is no literal load
		idle();
		acc_e = 8'ha5;
		chk("bank", {11'h0, bank_select_reg_o}, 16'h001f);
		chk("latch", {9'h0, program_counter_high_latch_o}, 16'h007f);
		chk("acc", {8'h0, accumulator_o}, 16'h00a5);
		chk("flags", {14'h0, flags_we_o, stall_o}, 16'h0);
	endtask : t_literals
	task automatic t_file();
		put(14'h305a);
		put(14'h00ff);
		idle();
		acc_e = 8'h5a;
		chk_store(16'h007f);
	endtask : t_file
	task automatic do_ind(input int n, input logic [1:0] m);
		logic [15:0] p, eff;
		p = ptr_e[n];
		case (m)
			LMX_MODE_PREINC:  p = p + 16'h1;
			LMX_MODE_PREDEC:  p = p - 16'h1;
			LMX_MODE_POSTINC: p = p + 16'h1;
			default:          p = p - 16'h1;
		endcase
		eff = (m == LMX_MODE_PREINC || m == LMX_MODE_PREDEC) ? p : ptr_e[n];
		ptr_e[n] = p;
		put(14'h0018 | 14'(n << 2) | 14'(m));
		idle();
		chk_store(eff);
		chk("ptr", n ? indirect_pointer1_o : indirect_pointer0_o, p);
	endtask : do_ind
	task automatic t_relative(input int n, input logic [5:0] k);
		put(14'h3f80 | 14'(n << 6) | 14'(k));
		idle();
		chk_store(ptr_e[n] + {{10{k[5]}}, k});
		chk("ptr", n ? indirect_pointer1_o : indirect_pointer0_o, ptr_e[n]);
	endtask : t_relative
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	initial
	begin
		wr_e = 16'h0;
		ptr_e[0] = LMX_PTR_RST;
		ptr_e[1] = LMX_PTR_RST;
		repeat (6) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		t_literals();
		t_file();
		for (int m = 0; m < 4; m++)
			do_ind(0, 2'(m));
		do_ind(0, LMX_MODE_POSTDEC); // below zero wraps
		put(14'h0080);
		idle();
		chk_store(ptr_e[0]); // alias 0 goes to pointer 0 address
		do_ind(1, LMX_MODE_PREDEC); // below zero wraps
		do_ind(1, LMX_MODE_PREINC); // above top wraps
		t_relative(1, 6'h20);
		t_relative(1, 6'h1f);
		t_relative(0, 6'h01); // offset past the top wraps
		do_ind(1, LMX_MODE_POSTDEC);
		put(14'h0081);
		idle();
		chk_store(ptr_e[1]); // alias goes to pointer address
		close_out();
	end
	initial
	begin
		repeat (2000) @(posedge mclk_i);
		error_cnt++;
		close_out();
	end
endmodule : lmx_move_exec_bench
